// ===== design/pdt_pkg.sv
// Overview of operation
// - run while condition on, reload when off, flag zero
// - hundredth delay preset 00.00 to 99.99 BCD
// - hundredth delay steps 0.01 s, finish within step
// - millisecond delay steps 0.001 s, integer preset
// - millisecond result seen once per scan
// - knob delay always occupies slot 15
// - knob delay preset comes from hardware knob
// - knob converted to BCD, 0.1 to 25.0 s
// - knob delay and knob1 readout share knob 1
// - knobs 1 and 2 both converted to BCD
// - interlock gate off resets every delay
// - power loss resets every delay
// - non-BCD preset sets fault flag, still runs
package pdt_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_1MS_NS = 1000000;
  localparam int TICK_1MS_CYCLES = (T_1MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] DECADE_LAST = 4'h9;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_HS_PRESET = 8'h04;
  localparam logic [7:0] OFS_MS_PRESET = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_HS_PV = 8'h10;
  localparam logic [7:0] OFS_MS_PV = 8'h14;
  localparam logic [7:0] OFS_KNOB_PV = 8'h18;
  localparam logic [7:0] OFS_KNOB_BCD = 8'h1c;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h20;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
  localparam logic [7:0] OFS_SCAN = 8'h28;
  localparam logic [7:0] OFS_SLOT_MAP = 8'h2c;

  localparam int NUM_DLY = 3;
  localparam int DLY_HS = 0;
  localparam int DLY_MS = 1;
  localparam int DLY_KNOB = 2;
  localparam int CTRL_IL_GATE = 3;
  localparam int IRQ_FAULT = 3;
  localparam int HS_SLOT_LSB = 16;
  localparam int KNOB2_LSB = 16;
  localparam logic [3:0] CTRL_RESET = 4'h8;
  localparam logic [15:0] PRESET_RESET = 16'h0000;
  localparam logic [3:0] HS_SLOT_RESET = 4'h0;
  localparam logic [3:0] SLOT_MS = 4'he;
  localparam logic [3:0] SLOT_KNOB = 4'hf;
  localparam logic [7:0] KNOB_MIN = 8'h01;
  localparam logic [7:0] KNOB_MAX = 8'hfa;
  localparam logic [11:0] KNOB_BCD_MIN = 12'h001;
  localparam logic [11:0] KNOB_BCD_MAX = 12'h250;

  typedef enum {BUS_IDLE, BUS_WR, BUS_RD1, BUS_RD2} pdt_bus_st_t;
endpackage

// ===== design/pdt_delay_timers.sv
// Decided for this implementation: the register offsets and the AHB-Lite slave port.
module pdt_delay_timers #(
  parameter int TICK_1MS_CYCLES = pdt_pkg::TICK_1MS_CYCLES
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [7:0] knob1_raw,
  input wire logic [7:0] knob2_raw,
  input wire logic power_lost,
  output logic irq
);
  localparam int CW = $clog2(TICK_1MS_CYCLES);
  localparam logic [CW-1:0] CNT_LAST = CW'(TICK_1MS_CYCLES - 1);

  if (TICK_1MS_CYCLES < 2) begin : g_chk
    $error("TICK_1MS_CYCLES must be at least 2");
  end

  function automatic logic is_bcd16(input logic [15:0] v);
    logic ok;
    ok = 1'b1;
    for (int k = 0; k < 4; k++) begin
      if (v[4*k +: 4] > 4'h9) ok = 1'b0;
    end
    return ok;
  endfunction

  // borrow ripples in decimal so a legal value never leaves BCD
  function automatic logic [15:0] bcd_dec16(input logic [15:0] v);
    logic [15:0] r;
    logic borrow;
    r = v;
    borrow = 1'b1;
    for (int k = 0; k < 4; k++) begin
      if (borrow) begin
        if (v[4*k +: 4] == 4'h0) begin
          r[4*k +: 4] = 4'h9;
        end else begin
          r[4*k +: 4] = v[4*k +: 4] - 4'h1;
          borrow = 1'b0;
        end
      end
    end
    return r;
  endfunction

  function automatic logic [11:0] knob_to_bcd(input logic [7:0] b);
    logic [19:0] s;
    logic [7:0] c;
    c = (b < pdt_pkg::KNOB_MIN) ? pdt_pkg::KNOB_MIN :
        (b > pdt_pkg::KNOB_MAX) ? pdt_pkg::KNOB_MAX : b;
    s = {12'h000, c};
    for (int k = 0; k < 8; k++) begin
      for (int d = 0; d < 3; d++) begin
        if (s[8+4*d +: 4] > 4'h4) s[8+4*d +: 4] = s[8+4*d +: 4] + 4'h3;
      end
      s = {s[18:0], 1'b0};
    end
    return s[19:8];
  endfunction

  // ---------------- bus slave ----------------
  pdt_pkg::pdt_bus_st_t bus_st_r;
  logic [7:0] addr_r;
  logic [31:0] rd_mux;
  logic accept;
  logic wr_en;

  assign accept = hsel & htrans[1] & hready;
  assign wr_en = (bus_st_r == pdt_pkg::BUS_WR) & ce;
  // one wait state on reads so read data comes from a flop and sees prior writes
  assign hreadyout = (bus_st_r != pdt_pkg::BUS_RD1);
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_st_r <= pdt_pkg::BUS_IDLE;
      addr_r <= 8'h00;
    end else if (ce) begin
      unique case (bus_st_r)
        pdt_pkg::BUS_RD1: bus_st_r <= pdt_pkg::BUS_RD2;
        pdt_pkg::BUS_IDLE, pdt_pkg::BUS_WR, pdt_pkg::BUS_RD2: begin
          if (accept) begin
            bus_st_r <= hwrite ? pdt_pkg::BUS_WR : pdt_pkg::BUS_RD1;
            addr_r <= haddr[7:0];
          end else begin
            bus_st_r <= pdt_pkg::BUS_IDLE;
          end
        end
      endcase
    end
  end

  // ---------------- control registers ----------------
  logic [3:0] ctrl_r;
  logic [15:0] hs_preset_r;
  logic [3:0] hs_slot_r;
  logic [15:0] ms_preset_r;
  logic [3:0] irq_mask_r;
  logic scan_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= pdt_pkg::CTRL_RESET;
      hs_preset_r <= pdt_pkg::PRESET_RESET;
      hs_slot_r <= pdt_pkg::HS_SLOT_RESET;
      ms_preset_r <= pdt_pkg::PRESET_RESET;
      irq_mask_r <= 4'h0;
      scan_r <= 1'b0;
    end else if (ce) begin
      scan_r <= wr_en & (addr_r == pdt_pkg::OFS_SCAN);
      if (wr_en) begin
        unique case (addr_r)
          pdt_pkg::OFS_CTRL: ctrl_r <= hwdata[3:0];
          pdt_pkg::OFS_HS_PRESET: begin
            hs_preset_r <= hwdata[15:0];
            hs_slot_r <= hwdata[pdt_pkg::HS_SLOT_LSB +: 4];
          end
          pdt_pkg::OFS_MS_PRESET: ms_preset_r <= hwdata[15:0];
          pdt_pkg::OFS_IRQ_MASK: irq_mask_r <= hwdata[3:0];
          default: ;
        endcase
      end
    end
  end
  // ---------------- knob conversion ----------------
  logic [11:0] knob1_bcd_r;
  logic [11:0] knob2_bcd_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      knob1_bcd_r <= pdt_pkg::KNOB_BCD_MIN;
      knob2_bcd_r <= pdt_pkg::KNOB_BCD_MIN;
    end else if (ce) begin
      knob1_bcd_r <= knob_to_bcd(knob1_raw);
      knob2_bcd_r <= knob_to_bcd(knob2_raw);
    end
  end

  // ---------------- prescaler ----------------
  logic [CW-1:0] cnt_1ms_r;
  logic [3:0] dec10_r;
  logic [3:0] dec100_r;
  logic tick_1ms_r;
  logic tick_10ms_r;
  logic tick_100ms_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_1ms_r <= '0;
      dec10_r <= 4'h0;
      dec100_r <= 4'h0;
      tick_1ms_r <= 1'b0;
      tick_10ms_r <= 1'b0;
      tick_100ms_r <= 1'b0;
    end else if (ce) begin
      tick_1ms_r <= (cnt_1ms_r == CNT_LAST);
      tick_10ms_r <= (cnt_1ms_r == CNT_LAST) && (dec10_r == pdt_pkg::DECADE_LAST);
      tick_100ms_r <= (cnt_1ms_r == CNT_LAST) && (dec10_r == pdt_pkg::DECADE_LAST) &&
                      (dec100_r == pdt_pkg::DECADE_LAST);
      if (cnt_1ms_r == CNT_LAST) begin
        cnt_1ms_r <= '0;
        dec10_r <= (dec10_r == pdt_pkg::DECADE_LAST) ? 4'h0 : dec10_r + 4'h1;
        if (dec10_r == pdt_pkg::DECADE_LAST) begin
          dec100_r <= (dec100_r == pdt_pkg::DECADE_LAST) ? 4'h0 : dec100_r + 4'h1;
        end
      end else begin
        cnt_1ms_r <= cnt_1ms_r + CW'(1);
      end
    end
  end

  // ---------------- delays ----------------
  logic [15:0] preset [pdt_pkg::NUM_DLY];
  logic [pdt_pkg::NUM_DLY-1:0] tick_sel;
  logic [pdt_pkg::NUM_DLY-1:0] run;
  logic [pdt_pkg::NUM_DLY-1:0] run_q_r;
  logic [pdt_pkg::NUM_DLY-1:0] done_r;
  logic [15:0] pv_r [pdt_pkg::NUM_DLY];
  logic clr;
  logic fault_evt;

  assign preset[pdt_pkg::DLY_HS] = hs_preset_r;
  assign preset[pdt_pkg::DLY_MS] = ms_preset_r;
  assign preset[pdt_pkg::DLY_KNOB] = {4'h0, knob1_bcd_r};
  assign tick_sel = {tick_100ms_r, tick_1ms_r, tick_10ms_r};
  assign clr = ~ctrl_r[pdt_pkg::CTRL_IL_GATE] | power_lost;
  assign run = ctrl_r[pdt_pkg::NUM_DLY-1:0] & {pdt_pkg::NUM_DLY{~clr}};
  // fault looked at when a delay starts; the knob preset is always legal
  assign fault_evt = (run[0] & ~run_q_r[0] & ~is_bcd16(preset[0])) |
                     (run[1] & ~run_q_r[1] & ~is_bcd16(preset[1]));

  for (genvar i = 0; i < pdt_pkg::NUM_DLY; i++) begin : g_dly
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        pv_r[i] <= 16'h0000;
        done_r[i] <= 1'b0;
        run_q_r[i] <= 1'b0;
      end else if (ce) begin
        run_q_r[i] <= run[i];
        if (!run[i]) begin
          pv_r[i] <= preset[i];
          done_r[i] <= 1'b0;
        end else if (pv_r[i] == 16'h0000) begin
          done_r[i] <= 1'b1;
        end else if (tick_sel[i]) begin
          pv_r[i] <= bcd_dec16(pv_r[i]);
        end
      end
    end
  end

  // the program sees the millisecond result only at its scan boundary
  logic ms_seen_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ms_seen_r <= 1'b0;
    end else if (ce && scan_r) begin
      ms_seen_r <= done_r[pdt_pkg::DLY_MS];
    end
  end

  logic [2:0] vis_done;
  logic [2:0] vis_done_q_r;
  logic [15:0] slot_map;
  assign vis_done = {done_r[pdt_pkg::DLY_KNOB], ms_seen_r, done_r[pdt_pkg::DLY_HS]};

  always_comb begin
    slot_map = 16'h0000;
    slot_map[hs_slot_r] = done_r[pdt_pkg::DLY_HS];
    slot_map[pdt_pkg::SLOT_MS] = slot_map[pdt_pkg::SLOT_MS] | ms_seen_r;
    slot_map[pdt_pkg::SLOT_KNOB] = slot_map[pdt_pkg::SLOT_KNOB] |
                                   done_r[pdt_pkg::DLY_KNOB];
  end

  // ---------------- interrupts ----------------
  logic [3:0] irq_st_r;
  logic [3:0] irq_set;
  logic [3:0] irq_clr;
  assign irq_set = {fault_evt, vis_done & ~vis_done_q_r};
  assign irq_clr = (wr_en && addr_r == pdt_pkg::OFS_IRQ_STATUS) ? hwdata[3:0] : 4'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_st_r <= 4'h0;
      vis_done_q_r <= 3'h0;
      irq <= 1'b0;
    end else if (ce) begin
      vis_done_q_r <= vis_done;
      // a new event beats a clear in the same cycle
      irq_st_r <= (irq_st_r & ~irq_clr) | irq_set;
      irq <= |(((irq_st_r & ~irq_clr) | irq_set) & irq_mask_r);
    end
  end

  // ---------------- read data ----------------
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (addr_r)
      pdt_pkg::OFS_CTRL: rd_mux[3:0] = ctrl_r;
      pdt_pkg::OFS_HS_PRESET: rd_mux = {12'h000, hs_slot_r, hs_preset_r};
      pdt_pkg::OFS_MS_PRESET: rd_mux[15:0] = ms_preset_r;
      pdt_pkg::OFS_STATUS: rd_mux[3:0] = {irq_st_r[pdt_pkg::IRQ_FAULT], vis_done};
      pdt_pkg::OFS_HS_PV: rd_mux[15:0] = pv_r[pdt_pkg::DLY_HS];
      pdt_pkg::OFS_MS_PV: rd_mux[15:0] = pv_r[pdt_pkg::DLY_MS];
      pdt_pkg::OFS_KNOB_PV: rd_mux[15:0] = pv_r[pdt_pkg::DLY_KNOB];
      pdt_pkg::OFS_KNOB_BCD: begin
        rd_mux[11:0] = knob1_bcd_r;
        rd_mux[pdt_pkg::KNOB2_LSB +: 12] = knob2_bcd_r;
      end
      pdt_pkg::OFS_IRQ_STATUS: rd_mux[3:0] = irq_st_r;
      pdt_pkg::OFS_IRQ_MASK: rd_mux[3:0] = irq_mask_r;
      pdt_pkg::OFS_SLOT_MAP: rd_mux[15:0] = slot_map;
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ce && bus_st_r == pdt_pkg::BUS_RD1) begin
      hrdata <= rd_mux;
    end
  end

  // ---------------- assertions ----------------
  property p_reload;
    @(posedge hclk) disable iff (!hresetn)
    (hresetn && ce && !run[pdt_pkg::DLY_HS]) |=> (pv_r[0] == $past(hs_preset_r)) && !done_r[0];
  endproperty
  a_reload: assert property (p_reload) else $error("idle delay not reloaded");

  property p_done_at_zero;
    @(posedge hclk) disable iff (!hresetn)
    (ce && run[0] && pv_r[0] == 16'h0000) |=> done_r[0];
  endproperty
  a_done_at_zero: assert property (p_done_at_zero) else $error("no flag at zero");

  property p_hs_step;
    @(posedge hclk) disable iff (!hresetn)
    (ce && run[0] && pv_r[0] != 16'h0000 && !tick_10ms_r) |=> $stable(pv_r[0]);
  endproperty
  a_hs_step: assert property (p_hs_step) else $error("hs value moved off tick");

  property p_bcd_clean;
    @(posedge hclk) disable iff (!hresetn)
    (ce && run[1] && is_bcd16(pv_r[1]) && is_bcd16(ms_preset_r)) |=> is_bcd16(pv_r[1]);
  endproperty
  a_bcd_clean: assert property (p_bcd_clean) else $error("value left BCD");

  property p_scan_only;
    @(posedge hclk) disable iff (!hresetn)
    !scan_r |=> $stable(ms_seen_r);
  endproperty
  a_scan_only: assert property (p_scan_only) else $error("ms flag moved off scan");

  property p_fixed_slots;
    @(posedge hclk) disable iff (!hresetn)
    (hs_slot_r < 4'he) |-> (slot_map[14] == ms_seen_r) && (slot_map[15] == done_r[2]);
  endproperty
  a_fixed_slots: assert property (p_fixed_slots) else $error("fixed slot wrong");

  property p_knob_range;
    @(posedge hclk) disable iff (!hresetn)
    (knob1_bcd_r >= pdt_pkg::KNOB_BCD_MIN) && (knob1_bcd_r <= pdt_pkg::KNOB_BCD_MAX);
  endproperty
  a_knob_range: assert property (p_knob_range) else $error("knob out of range");

  property p_knob_preset;
    @(posedge hclk) disable iff (!hresetn)
    (hresetn && ce && !run[2]) |=> pv_r[2] == {4'h0, $past(knob1_bcd_r)};
  endproperty
  a_knob_preset: assert property (p_knob_preset) else $error("knob preset wrong");

  property p_gate_off;
    @(posedge hclk) disable iff (!hresetn)
    (ce && clr) |=> done_r == 3'h0;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("gate off kept flag");

  property p_fault;
    @(posedge hclk) disable iff (!hresetn)
    (ce && fault_evt) |=> irq_st_r[pdt_pkg::IRQ_FAULT] ##1 1'b1;
  endproperty
  a_fault: assert property (p_fault) else $error("fault flag not set");

  property p_tick_gap;
    @(posedge hclk) disable iff (!hresetn)
    (ce && tick_1ms_r) |=> !tick_1ms_r;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick wider than one cycle");

  c_hs_done: cover property (@(posedge hclk) disable iff (!hresetn) $rose(done_r[0]));
  c_ms_seen: cover property (@(posedge hclk) disable iff (!hresetn) $rose(ms_seen_r));
  c_knob_done: cover property (@(posedge hclk) disable iff (!hresetn) $rose(done_r[2]));
  c_fault: cover property (@(posedge hclk) disable iff (!hresetn) fault_evt);
endmodule

// ===== test/pdt_ladder_model.sv
module pdt_ladder_model (
  input wire logic hclk,
  input wire logic hreadyout,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end

  // ready is sampled at the rising edge, the same value the slave acts on
  task automatic wait_rdy;
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
  endtask

  task automatic addr_phase(input logic [7:0] a, input logic wr);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    htrans <= 2'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    // released address lines must not keep showing the old value
    haddr <= ~{24'h00_0000, a};
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_phase(a, 1'b1);
    hwdata <= d;
    wait_rdy();
    hwdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a);
    addr_phase(a, 1'b0);
    wait_rdy();
  endtask

  // one scan of the program ends with this write
  task automatic scan;
    wr(pdt_pkg::OFS_SCAN, 32'h0000_0001);
  endtask
endmodule

// ===== test/pdt_delay_timers_tb_top.sv
module pdt_delay_timers_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TK = 20;
  logic hclk, hresetn, ce, power_lost, rd_pend;
  logic [7:0] knob1_raw, knob2_raw, k1, k2;
  wire logic hsel, hwrite, hreadyout, hresp, irq;
  wire logic [31:0] haddr, hwdata, hrdata;
  wire logic [1:0] htrans;
  wire logic [2:0] hsize;
  logic [31:0] q_a[$], q_b[$], ea, eb;
  int error_cnt, n_tests, cyc;

  pdt_ladder_model i_pdt_ladder_model (.hclk(hclk), .hreadyout(hreadyout), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  pdt_delay_timers #(.TICK_1MS_CYCLES(TK)) i_pdt_delay_timers (.hclk(hclk),
    .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .knob1_raw(knob1_raw), .knob2_raw(knob2_raw),
    .power_lost(power_lost), .irq(irq));

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] d);
    i_pdt_ladder_model.wr(a, d);
  endtask

  // alt gives a second acceptable value where tick phase is not fixed
  task automatic r(input logic [7:0] a, input logic [31:0] e, input logic [31:0] alt);
    q_a.push_back(e);
    q_b.push_back(alt);
    i_pdt_ladder_model.rd(a);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
  endtask

  function automatic logic [11:0] bcd3(input int v);
    int c;
    c = (v < 1) ? 1 : ((v > 250) ? 250 : v);
    return {4'(c / 100), 4'((c / 10) % 10), 4'(c % 10)};
  endfunction

  always @(negedge hclk) begin
    if (rd_pend && hreadyout === 1'b1) begin
      ea = q_a.pop_front();
      eb = q_b.pop_front();
      chk(hrdata, (hrdata === eb) ? eb : ea);
      chk(32'(hresp), 32'h0);
      rd_pend = 1'b0;
    end
    if (hsel === 1'b1 && htrans[1] === 1'b1 && hreadyout === 1'b1 && hwrite === 1'b0)
      rd_pend = 1'b1;
  end

  always @(posedge hclk) begin
    cyc++;
    if (cyc == 12000) begin
      error_cnt++;
      conclude();
    end
  end

  initial begin
    hresetn = 1'b0;
    ce = 1'b1;
    power_lost = 1'b0;
    knob1_raw = 8'h02;
    knob2_raw = 8'h05;
    rd_pend = 1'b0;
    void'($urandom(32'h556c));
    wt(16);
    hresetn <= 1'b1;
    wt(1);
    r(pdt_pkg::OFS_CTRL, 32'h8, 32'h8);
    r(pdt_pkg::OFS_IRQ_MASK, 32'h0, 32'h0);
    w(8'h30, 32'hffff_ffff);
    r(8'h30, 32'h0, 32'h0);
    w(pdt_pkg::OFS_HS_PRESET, 32'h0009_9999);
    r(pdt_pkg::OFS_HS_PRESET, 32'h0009_9999, 32'h0009_9999);
    r(pdt_pkg::OFS_HS_PV, 32'h9999, 32'h9999);
    w(pdt_pkg::OFS_IRQ_MASK, 32'h9);
    w(pdt_pkg::OFS_HS_PRESET, 32'h0005_0003);
    w(pdt_pkg::OFS_CTRL, 32'h9);
    wt(370);
    r(pdt_pkg::OFS_STATUS, 32'h0, 32'h0);
    wt(250);
    r(pdt_pkg::OFS_STATUS, 32'h1, 32'h1);
    r(pdt_pkg::OFS_SLOT_MAP, 32'h20, 32'h20);
    r(pdt_pkg::OFS_IRQ_STATUS, 32'h1, 32'h1);
    chk(32'(irq), 32'h1);
    w(pdt_pkg::OFS_CTRL, 32'h1);
    r(pdt_pkg::OFS_STATUS, 32'h0, 32'h0);
    r(pdt_pkg::OFS_HS_PV, 32'h3, 32'h3);
    w(pdt_pkg::OFS_IRQ_STATUS, 32'h1);
    r(pdt_pkg::OFS_IRQ_STATUS, 32'h0, 32'h0);
    chk(32'(irq), 32'h0);
    w(pdt_pkg::OFS_HS_PRESET, 32'h0100);
    w(pdt_pkg::OFS_CTRL, 32'h9);
    wt(150);
    r(pdt_pkg::OFS_HS_PV, 32'h100, 32'h99);
    // a frozen block must not count, so the next reading is only one step lower
    ce <= 1'b0;
    wt(400);
    ce <= 1'b1;
    wt(60);
    r(pdt_pkg::OFS_HS_PV, 32'h99, 32'h98);
    w(pdt_pkg::OFS_MS_PRESET, 32'h10);
    w(pdt_pkg::OFS_CTRL, 32'ha);
    wt(260);
    r(pdt_pkg::OFS_STATUS, 32'h0, 32'h0);
    i_pdt_ladder_model.scan();
    r(pdt_pkg::OFS_STATUS, 32'h2, 32'h2);
    r(pdt_pkg::OFS_SLOT_MAP, 32'h4000, 32'h4000);
    w(pdt_pkg::OFS_CTRL, 32'h8);
    i_pdt_ladder_model.scan();
    for (int i = 0; i < 3; i++) begin
      k1 = (i == 0) ? 8'($urandom_range(1, 250)) : ((i == 1) ? 8'h00 : 8'hff);
      k2 = 8'($urandom);
      knob1_raw <= k1;
      knob2_raw <= k2;
      wt(3);
      r(pdt_pkg::OFS_KNOB_BCD, {4'h0, bcd3(k2), 4'h0, bcd3(k1)},
        {4'h0, bcd3(k2), 4'h0, bcd3(k1)});
    end
    knob1_raw <= 8'h02;
    wt(3);
    r(pdt_pkg::OFS_KNOB_PV, 32'h2, 32'h2);
    w(pdt_pkg::OFS_CTRL, 32'hc);
    // one step early is legal, so look before one full step has passed and after the full preset
    wt(1900);
    r(pdt_pkg::OFS_STATUS, 32'h0, 32'h0);
    wt(2110);
    r(pdt_pkg::OFS_STATUS, 32'h4, 32'h4);
    r(pdt_pkg::OFS_SLOT_MAP, 32'h8000, 32'h8000);
    power_lost <= 1'b1;
    wt(2);
    r(pdt_pkg::OFS_STATUS, 32'h0, 32'h0);
    r(pdt_pkg::OFS_KNOB_PV, 32'h2, 32'h2);
    power_lost <= 1'b0;
    w(pdt_pkg::OFS_CTRL, 32'h8);
    w(pdt_pkg::OFS_IRQ_STATUS, 32'hf);
    w(pdt_pkg::OFS_MS_PRESET, 32'ha);
    w(pdt_pkg::OFS_CTRL, 32'ha);
    r(pdt_pkg::OFS_IRQ_STATUS, 32'h8, 32'h8);
    r(pdt_pkg::OFS_STATUS, 32'h8, 32'h8);
    chk(32'(irq), 32'h1);
    conclude();
  end
endmodule
